// ---- core/tleb_device.sv ----
// processor-side link terminator with event block buffers and registers
`timescale 1ns/10ps
module tleb_device
  import tleb_pkg::*;
#(
  parameter int DATA_DEPTH = 256,
  parameter int LEN_DEPTH  = 16
) (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        clkEn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  // link
  tleb_link_if.device      lnk,
  // hardware readout side
  output logic             readoutMode,
  input  wire logic        hwDataPop,
  input  wire logic        hwLenPop,
  output logic [32:0]      hwDataHead,
  output logic [16:0]      hwLenHead
);
  localparam int DAW = $clog2(DATA_DEPTH);
  localparam int LAW = $clog2(LEN_DEPTH);

  // bus and control registers
  logic [3:0]  rstCtl, next_rstCtl;
  logic        mode, next_mode;
  logic        wrPend, next_wrPend;
  logic [7:0]  wrAddr, next_wrAddr;
  logic [31:0] next_hrdata;
  logic        reqPend, next_reqPend, ackPend, next_ackPend;
  logic        addrOk, busPopData, busPopLen;
  // link sampling and reply
  logic [1:0]  clkSync, datSync;
  logic        clkLast, lnkRise, lnkFall;
  logic [2:0]  txSh, next_txSh;
  logic [1:0]  txLeft, next_txLeft;
  logic        replyQ, next_replyQ;
  // receiver
  logic        rxBusy, next_rxBusy;
  logic [5:0]  rxCnt, next_rxCnt;
  logic [33:0] rxSh, next_rxSh;
  logic [7:0]  gapCnt, next_gapCnt;
  logic        rxLocked, next_rxLocked, rxReady, next_rxReady;
  logic [15:0] errCnt, next_errCnt;
  logic        cmdValid, next_cmdValid;
  logic [33:0] cmdWord, next_cmdWord;
  logic [7:0]  curLevel, next_curLevel, nxtLevel, next_nxtLevel;
  logic [15:0] blkLen, next_blkLen;
  logic        frameDone, frameBad;
  logic [34:0] frame;
  // buffers
  logic [32:0] dMem [DATA_DEPTH];
  logic [16:0] lMem [LEN_DEPTH];
  logic [DAW-1:0] dWr, next_dWr, dRd, next_dRd;
  logic [LAW-1:0] lWr, next_lWr, lRd, next_lRd;
  logic [DAW:0]   dCnt, next_dCnt;
  logic [LAW:0]   lCnt, next_lCnt;
  logic        dPush, lPush, dPop, lPop, dEmpty, lEmpty;
  logic [32:0] dIn;
  logic [16:0] lIn;
  logic [31:0] evStatus;

  assign hreadyout   = 1'b1;  // zero wait states
  assign hresp       = 1'b0;
  assign readoutMode = mode;
  assign lnk.lnkReply = replyQ;
  assign lnkRise = clkSync[1] && !clkLast;
  assign lnkFall = !clkSync[1] && clkLast;
  assign dEmpty = (dCnt == '0);
  assign lEmpty = (lCnt == '0);
  assign hwDataHead = dMem[dRd];
  assign hwLenHead  = lMem[lRd];
  assign addrOk = hsel && htrans[1] && hready;

  // event buffer status word
  always_comb begin
    evStatus = 32'h00000000;
    evStatus[BIT_HEAD_SYNC] = !lEmpty && hwLenHead[16];
    evStatus[DCNT_LSB +: DCNT_W] = DCNT_W'(dCnt);
    evStatus[BIT_END_MARKER] = !dEmpty && hwDataHead[32];
    evStatus[LCNT_LSB +: LCNT_W] = LCNT_W'(lCnt);
    evStatus[BIT_LEN_EMPTY] = lEmpty;
    evStatus[BIT_DATA_EMPTY] = dEmpty;
  end

  // bus decode: reads answer in the data phase, writes land there
  always_comb begin
    next_wrPend = addrOk && hwrite;
    next_wrAddr = haddr[7:0];
    next_hrdata = 32'h00000000;
    busPopData = 1'b0;
    busPopLen  = 1'b0;
    if (addrOk && !hwrite) begin
      if (haddr[7:0] == OFS_LINK_RESET) begin
        // reserved bit 1 still shows its reset one until written
        next_hrdata = {28'h0000000, rstCtl};
      end else if (haddr[7:0] == OFS_LINK_CONTROL) begin
        next_hrdata[BIT_MODE] = mode;  // send bits are write-only
      end else if (haddr[7:0] == OFS_LINK_STATUS) begin
        next_hrdata = {14'h0000, rxLocked, rxReady, errCnt};
      end else if (haddr[7:0] == OFS_BLOCK_LEVEL) begin
        next_hrdata = {16'h0000, nxtLevel, curLevel};
      end else if (haddr[7:0] == OFS_EB_STATUS) begin
        next_hrdata = evStatus;
      end else if (haddr[7:0] == OFS_DATA_PORT) begin
        next_hrdata = hwDataHead[31:0];
        busPopData  = !mode;
      end else if (haddr[7:0] == OFS_LENGTH_PORT) begin
        next_hrdata = {16'h0000, hwLenHead[15:0]};
        busPopLen   = !mode;
      end
    end
    next_rstCtl = rstCtl;
    next_mode   = mode;
    next_reqPend = reqPend;
    next_ackPend = ackPend;
    if (lnkFall && txLeft == 2'h0) begin
      // request goes first when both wait
      if (reqPend) begin
        next_reqPend = 1'b0;
      end else if (ackPend) begin
        next_ackPend = 1'b0;
      end
    end
    if (wrPend && wrAddr == OFS_LINK_RESET) begin
      next_rstCtl = hwdata[3:0] & 4'hD;
    end else if (wrPend && wrAddr == OFS_LINK_CONTROL) begin
      next_mode = hwdata[BIT_MODE];
      // a new write wins over the take of the previous one
      if (hwdata[BIT_SEND_BLOCK_LEVEL_REQUEST]) next_reqPend = 1'b1;
      if (hwdata[BIT_SEND_ACK]) next_ackPend = 1'b1;
    end
  end

  // reply sender: start bit then code, changed after link falls
  always_comb begin
    next_txSh   = txSh;
    next_txLeft = txLeft;
    next_replyQ = replyQ;
    if (lnkFall) begin
      if (txLeft != 2'h0) begin
        next_replyQ = txSh[2];
        next_txSh   = {txSh[1:0], 1'b1};
        next_txLeft = txLeft - 2'h1;
      end else if (reqPend || ackPend) begin
        next_replyQ = 1'b0;
        next_txSh   = {reqPend ? RC_REQUEST : RC_ACK, 1'b1};
        next_txLeft = 2'(REPLY_BITS);
      end else begin
        next_replyQ = 1'b1;
      end
    end
  end

  // receiver, lock watch and command decode
  always_comb begin
    frame = {rxSh, datSync[1]};
    frameDone = lnkRise && rxBusy && rxCnt == 6'(FRAME_BITS - 1);
    frameBad = (^frame) || frame[34:33] == FT_BAD;
    next_rxBusy = rxBusy;
    next_rxCnt  = rxCnt;
    next_rxSh   = rxSh;
    next_errCnt = errCnt;
    next_rxReady = rxReady;
    next_gapCnt = lnkRise ? 8'h00 : (rxLocked ? gapCnt + 8'h01 : gapCnt);
    next_rxLocked = rxLocked;
    if (lnkRise) begin
      next_rxLocked = 1'b1;
    end else if (gapCnt == 8'(LOCK_TIMEOUT_CYC)) begin
      next_rxLocked = 1'b0;
      next_rxReady  = 1'b0;
    end
    if (lnkRise) begin
      if (!rxBusy) begin
        next_rxBusy = !datSync[1];
        next_rxCnt  = 6'h00;
      end else begin
        next_rxSh  = frame[33:0];
        next_rxCnt = rxCnt + 6'h01;
        if (frameDone) begin
          next_rxBusy = 1'b0;
        end
      end
    end
    if (frameDone && frameBad && errCnt != 16'hFFFF) begin
      next_errCnt = errCnt + 16'h0001;
    end else if (frameDone && !frameBad) begin
      next_rxReady = 1'b1;
    end
    // one-word command stage, dropped while held in reset
    next_cmdValid = frameDone && !frameBad && !rstCtl[BIT_COMMAND_FIFO_RESET];
    next_cmdWord  = frame[34:1];
    if (rstCtl[BIT_RECEIVER_RESET]) begin
      next_rxBusy = 1'b0;
      next_rxLocked = 1'b0;
      next_rxReady = 1'b0;
      next_errCnt = 16'h0000;
      next_cmdValid = 1'b0;
    end
  end

  // command actions and buffer pointers
  always_comb begin
    next_curLevel = curLevel;
    next_nxtLevel = nxtLevel;
    next_blkLen = blkLen;
    dPush = 1'b0;
    lPush = 1'b0;
    dIn = {1'b0, cmdWord[31:0]};
    lIn = {cmdWord[0], blkLen + 16'h0001};
    if (cmdValid) begin
      if (cmdWord[33:32] == FT_LEVEL) begin
        next_curLevel = cmdWord[7:0];
        next_nxtLevel = cmdWord[15:8];
      end else if (cmdWord[33:32] == FT_WORD) begin
        dPush = (dCnt != (DAW+1)'(DATA_DEPTH));  // full drops the word
        next_blkLen = blkLen + 16'(dPush);
      end else if (cmdWord[33:32] == FT_END) begin
        // dummy marker closes the block, sync flag rides the length
        dIn = {1'b1, 32'hFFFFFFFF};
        dPush = (dCnt != (DAW+1)'(DATA_DEPTH));
        lPush = (lCnt != (LAW+1)'(LEN_DEPTH));
        next_blkLen = 16'h0000;
      end
    end
    dPop = (busPopData || (mode && hwDataPop)) && !dEmpty;
    lPop = (busPopLen || (mode && hwLenPop)) && !lEmpty;
    next_dWr = dWr + DAW'(dPush);
    next_dRd = dRd + DAW'(dPop);
    next_dCnt = dCnt + (DAW+1)'(dPush) - (DAW+1)'(dPop);
    next_lWr = lWr + LAW'(lPush);
    next_lRd = lRd + LAW'(lPop);
    next_lCnt = lCnt + (LAW+1)'(lPush) - (LAW+1)'(lPop);
    if (rstCtl[BIT_EVENT_BUFFER_RESET]) begin
      next_dWr = '0;
      next_dRd = '0;
      next_dCnt = '0;
      next_lWr = '0;
      next_lRd = '0;
      next_lCnt = '0;
      next_blkLen = 16'h0000;
    end
  end

  // buffer memories
  always_ff @(posedge clk_sys) begin
    if (clkEn && dPush) dMem[dWr] <= dIn;
    if (clkEn && lPush) lMem[lWr] <= lIn;
  end

  // state registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rstCtl <= RST_LINK_RESET;
      mode <= 1'b0;
      wrPend <= 1'b0;
      wrAddr <= 8'h00;
      hrdata <= 32'h00000000;
      reqPend <= 1'b0;
      ackPend <= 1'b0;
      clkSync <= 2'h0;
      datSync <= 2'h3;
      clkLast <= 1'b0;
      txSh <= 3'h7;
      txLeft <= 2'h0;
      replyQ <= 1'b1;
      rxBusy <= 1'b0;
      rxCnt <= 6'h00;
      rxSh <= '0;
      gapCnt <= 8'h00;
      rxLocked <= 1'b0;
      rxReady <= 1'b0;
      errCnt <= 16'h0000;
      cmdValid <= 1'b0;
      cmdWord <= '0;
      curLevel <= 8'h00;
      nxtLevel <= 8'h00;
      blkLen <= 16'h0000;
      dWr <= '0;
      dRd <= '0;
      dCnt <= '0;
      lWr <= '0;
      lRd <= '0;
      lCnt <= '0;
    end else if (clkEn) begin
      rstCtl <= next_rstCtl;
      mode <= next_mode;
      wrPend <= next_wrPend;
      wrAddr <= next_wrAddr;
      hrdata <= next_hrdata;
      reqPend <= next_reqPend;
      ackPend <= next_ackPend;
      clkSync <= {clkSync[0], lnk.lnkClk};
      datSync <= {datSync[0], lnk.lnkData};
      clkLast <= clkSync[1];
      txSh <= next_txSh;
      txLeft <= next_txLeft;
      replyQ <= next_replyQ;
      rxBusy <= next_rxBusy;
      rxCnt <= next_rxCnt;
      rxSh <= next_rxSh;
      gapCnt <= next_gapCnt;
      rxLocked <= next_rxLocked;
      rxReady <= next_rxReady;
      errCnt <= next_errCnt;
      cmdValid <= next_cmdValid;
      cmdWord <= next_cmdWord;
      curLevel <= next_curLevel;
      nxtLevel <= next_nxtLevel;
      blkLen <= next_blkLen;
      dWr <= next_dWr;
      dRd <= next_dRd;
      dCnt <= next_dCnt;
      lWr <= next_lWr;
      lRd <= next_lRd;
      lCnt <= next_lCnt;
    end
  end
endmodule // tleb_device

// ---- core/tleb_tdm.sv ----
// trigger distribution module end: clock divider, frame sender, reply rx
`timescale 1ns/10ps
module tleb_tdm
  import tleb_pkg::*;
#(
  parameter int DIV = LINK_DIV
) (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        clkEn,
  // link
  tleb_link_if.tdm         lnk,
  // user side requests
  input  wire logic        sendLevel,
  input  wire logic [7:0]  nextLevel,
  input  wire logic [7:0]  curLevel,
  input  wire logic        sendWord,
  input  wire logic [31:0] wordData,
  input  wire logic        sendEnd,
  input  wire logic        endSync,
  output logic             txBusy,
  // user side answers
  output logic             reqSeen,
  output logic             ackSeen
);
  localparam int HALF = DIV / 2;
  logic [7:0]  divCnt, next_divCnt;
  logic        clkQ, next_clkQ;
  logic [34:0] txSh, next_txSh;
  logic [5:0]  txLeft, next_txLeft;
  logic        datQ, next_datQ;
  logic [1:0]  rpSync;
  logic        rpBusy, next_rpBusy;
  logic [1:0]  rpSh, next_rpSh;
  logic [1:0]  rpCnt, next_rpCnt;
  logic        next_reqSeen, next_ackSeen;
  logic        fall, rise;
  logic [1:0]  ftype;
  logic [31:0] fdata;

  assign lnk.lnkClk  = clkQ;
  assign lnk.lnkData = datQ;
  assign txBusy      = (txLeft != 6'h00);
  assign fall = clkQ && (divCnt == 8'(HALF - 1));
  assign rise = !clkQ && (divCnt == 8'(HALF - 1));

  // divider, sender and reply receiver next state
  always_comb begin
    next_divCnt  = (divCnt == 8'(HALF - 1)) ? 8'h00 : divCnt + 8'h01;
    next_clkQ    = (divCnt == 8'(HALF - 1)) ? !clkQ : clkQ;
    next_txSh    = txSh;
    next_txLeft  = txLeft;
    next_datQ    = datQ;
    ftype = FT_WORD;
    fdata = wordData;
    if (sendLevel) begin
      ftype = FT_LEVEL;
      fdata = {16'h0000, nextLevel, curLevel};
    end else if (sendEnd) begin
      ftype = FT_END;
      fdata = {31'h00000000, endSync};
    end
    // a strobe while busy is ignored
    if (!txBusy && (sendLevel || sendWord || sendEnd)) begin
      next_txSh   = {ftype, fdata, ^{ftype, fdata}};
      next_txLeft = 6'(FRAME_BITS + 1);
    end
    // data changes only at falling link edges, stable at the rise
    if (fall) begin
      if (txLeft == 6'(FRAME_BITS + 1)) begin
        next_datQ = 1'b0;
        next_txLeft = txLeft - 6'h01;
      end else if (txBusy) begin
        next_datQ = txSh[34];
        next_txSh = {txSh[33:0], 1'b1};
        next_txLeft = txLeft - 6'h01;
      end else begin
        next_datQ = 1'b1;
      end
    end
    // reply bits are sampled just before each falling edge
    next_rpBusy  = rpBusy;
    next_rpSh    = rpSh;
    next_rpCnt   = rpCnt;
    next_reqSeen = 1'b0;
    next_ackSeen = 1'b0;
    if (fall) begin
      if (!rpBusy && !rpSync[1]) begin
        next_rpBusy = 1'b1;
        next_rpCnt  = 2'h0;
      end else if (rpBusy) begin
        next_rpSh  = {rpSh[0], rpSync[1]};
        next_rpCnt = rpCnt + 2'h1;
        if (rpCnt == 2'(REPLY_BITS - 1)) begin
          next_rpBusy  = 1'b0;
          next_reqSeen = ({rpSh[0], rpSync[1]} == RC_REQUEST);
          next_ackSeen = ({rpSh[0], rpSync[1]} == RC_ACK);
        end
      end
    end
  end

  // registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      divCnt <= 8'h00;
      clkQ <= 1'b0;
      txSh <= '0;
      txLeft <= 6'h00;
      datQ <= 1'b1;
      rpSync <= 2'h3;
      rpBusy <= 1'b0;
      rpSh <= 2'h0;
      rpCnt <= 2'h0;
      reqSeen <= 1'b0;
      ackSeen <= 1'b0;
    end else if (clkEn) begin
      divCnt <= next_divCnt;
      clkQ <= next_clkQ;
      txSh <= next_txSh;
      txLeft <= next_txLeft;
      datQ <= next_datQ;
      rpSync <= {rpSync[0], lnk.lnkReply};
      rpBusy <= next_rpBusy;
      rpSh <= next_rpSh;
      rpCnt <= next_rpCnt;
      reqSeen <= next_reqSeen;
      ackSeen <= next_ackSeen;
    end
  end
endmodule // tleb_tdm

// ---- include/tleb_link_if.sv ----
// serial link between buffer peripheral and trigger distribution module
`timescale 1ns/10ps
interface tleb_link_if;
  logic lnkClk;   // link clock, made by the distribution module
  logic lnkData;  // frames toward the peripheral
  logic lnkReply; // requests and acknowledgements back
  modport device (input lnkClk, input lnkData, output lnkReply);
  modport tdm    (output lnkClk, output lnkData, input lnkReply);
endinterface

// ---- include/tleb_pkg.sv ----
// constants shared by both ends of the trigger link event buffer
package tleb_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_LINK_RESET   = 8'h00;
  localparam logic [7:0] OFS_LINK_CONTROL = 8'h04;
  localparam logic [7:0] OFS_LINK_STATUS  = 8'h08;
  localparam logic [7:0] OFS_BLOCK_LEVEL  = 8'h0C;
  localparam logic [7:0] OFS_EB_STATUS    = 8'h14;
  localparam logic [7:0] OFS_DATA_PORT    = 8'h18;
  localparam logic [7:0] OFS_LENGTH_PORT  = 8'h24;
  // reset values
  localparam logic [3:0] RST_LINK_RESET   = 4'hF;
  // link reset control bits
  localparam int BIT_RECEIVER_RESET    = 0;
  localparam int BIT_COMMAND_FIFO_RESET = 2;
  localparam int BIT_EVENT_BUFFER_RESET = 3;
  // link control bits
  localparam int BIT_SEND_BLOCK_LEVEL_REQUEST       = 0;
  localparam int BIT_SEND_ACK          = 1;
  localparam int BIT_MODE              = 4;
  // link status fields
  localparam int BIT_RX_LOCKED         = 17;
  localparam int BIT_RX_READY          = 16;
  // event buffer status fields
  localparam int BIT_HEAD_SYNC         = 31;
  localparam int DCNT_LSB              = 17;
  localparam int DCNT_W                = 14;
  localparam int BIT_END_MARKER        = 16;
  localparam int LCNT_LSB              = 7;
  localparam int LCNT_W                = 9;
  localparam int BIT_LEN_EMPTY         = 4;
  localparam int BIT_DATA_EMPTY        = 0;
  // link timing
  localparam int CLK_PERIOD_NS         = 100;
  localparam int LINK_PERIOD_NS        = 800;
  localparam int LINK_DIV              = LINK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int LOCK_TIMEOUT_CYC      = 4 * LINK_DIV;
  // forward frame: start, type(2), data(32), even parity
  localparam int FRAME_BITS            = 35;
  localparam int REPLY_BITS            = 2;
  typedef enum logic [1:0] {
    FT_LEVEL,
    FT_WORD,
    FT_END,
    FT_BAD
  } tleb_frame_t;
  localparam logic [1:0] RC_REQUEST    = 2'h1;
  localparam logic [1:0] RC_ACK        = 2'h2;
endpackage

// ---- verification/tleb_sva.sv ----
// bus and link checker for the trigger link event buffer pair
`timescale 1ns/10ps
module tleb_sva
  import tleb_pkg::*;
(
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        rst,
  // link wires
  input wire logic        lnkClk,
  input wire logic        lnkData,
  input wire logic        lnkReply,
  // device bus side
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic        hresp,
  input wire logic        readoutMode
);
  logic modeBit;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // mode bit split out so that past sees a plain signal
  assign modeBit = hwdata[4];

  // transfers taken at one register offset
  sequence rd_s(logic [7:0] ofs);
    hsel && htrans[1] && !hwrite && haddr[7:0] == ofs;
  endsequence
  sequence wr_s(logic [7:0] ofs);
    hsel && htrans[1] && hwrite && haddr[7:0] == ofs;
  endsequence

  bus_ready_a: assert property (hreadyout && !hresp)
    else $error("bus stalled or answered an error");
  reset_value_a: assert property ($past(rst) ##0 rd_s(OFS_LINK_RESET)
    |=> hrdata == 32'(RST_LINK_RESET))
    else $error("reset register value wrong");
  ctl_readback_a: assert property (rd_s(OFS_LINK_CONTROL)
    |=> (hrdata & 32'hFFFFFFEF) == 32'h0) else $error("pulse bits read back");
  mode_write_a: assert property (wr_s(OFS_LINK_CONTROL) ##1 1'h1
    |=> readoutMode == $past(modeBit)) else $error("mode not taken");
  request_sent_a: assert property (wr_s(OFS_LINK_CONTROL) ##1 hwdata[0]
    |-> ##[1:40] !lnkReply) else $error("no request on reply line");
  ack_sent_a: assert property (wr_s(OFS_LINK_CONTROL) ##1 hwdata[1]
    |-> ##[1:40] !lnkReply) else $error("no ack on reply line");
  level_field_a: assert property (rd_s(OFS_BLOCK_LEVEL)
    |=> hrdata[31:16] == 16'h0000) else $error("level upper bits set");
  link_status_a: assert property (rd_s(OFS_LINK_STATUS)
    |=> hrdata[31:18] == 14'h0000 && (!hrdata[16] || hrdata[17]))
    else $error("link status fields wrong");
  data_empty_a: assert property (rd_s(OFS_EB_STATUS)
    |=> hrdata[0] == (hrdata[30:17] == 14'h0000))
    else $error("data empty flag and count disagree");
  len_empty_a: assert property (rd_s(OFS_EB_STATUS)
    |=> hrdata[4] == (hrdata[15:7] == 9'h000))
    else $error("length empty flag and count disagree");
  idle_wire_a: assert property ($past(rst) |-> lnkReply && lnkData)
    else $error("link lines not idle after reset");
endmodule // tleb_sva

// ---- verification/tleb_tb.sv ----
// self-checking bench: device and distribution module joined by the link
`timescale 1ns/10ps
module tleb_tb
  import tleb_pkg::*;
;
  logic        clk_sys, rst, hsel, hwrite, hreadyout, hresp, readoutMode;
  logic [31:0] haddr, hwdata, hrdata, rdVal, wordData;
  logic [1:0]  htrans;
  logic        sendLevel, sendWord, sendEnd, endSync, txBusy, reqSeen, ackSeen;
  logic [7:0]  nextLevel, curLevel;
  logic        hwDataPop;
  logic [32:0] dataHead;
  int          n_fail, n_tests;

  tleb_link_if tleb_link_if_i ();
  tleb_device tleb_device_i (.clk_sys(clk_sys), .rst(rst), .clkEn(1'h1),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .lnk(tleb_link_if_i.device), .readoutMode(readoutMode),
    .hwDataPop(hwDataPop), .hwLenPop(1'h0), .hwDataHead(dataHead),
    .hwLenHead());
  tleb_tdm tleb_tdm_i (.clk_sys(clk_sys), .rst(rst), .clkEn(1'h1),
    .lnk(tleb_link_if_i.tdm), .sendLevel(sendLevel), .nextLevel(nextLevel),
    .curLevel(curLevel), .sendWord(sendWord), .wordData(wordData),
    .sendEnd(sendEnd), .endSync(endSync), .txBusy(txBusy),
    .reqSeen(reqSeen), .ackSeen(ackSeen));
  tleb_sva tleb_sva_i (.clk_sys(clk_sys), .rst(rst),
    .lnkClk(tleb_link_if_i.lnkClk), .lnkData(tleb_link_if_i.lnkData),
    .lnkReply(tleb_link_if_i.lnkReply), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .readoutMode(readoutMode));

  // 10 MHz system clock
  initial begin
    clk_sys = 1'h0;
    forever #50 clk_sys = ~clk_sys;
  end

  // verdict and end of run
  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, got);
    n_tests++;
    if (got !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, got);
    end
  endtask

  // single ahb transfer; each phase held until hready is seen high
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
    int k;
    k = 0;
    hsel   <= 1'h1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr  <= {24'h000000, a};
    do begin
      @(posedge clk_sys);
      k++;
    end while (hreadyout !== 1'h1 && k < 50);
    hsel   <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    do begin
      @(posedge clk_sys);
      k++;
    end while (hreadyout !== 1'h1 && k < 100);
    rdVal = hrdata;
    if (k >= 100) begin
      n_fail++;
      results();
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m, e,
                    input string nm);
    xfer(1'h0, a, 32'h00000000);
    chk(nm, e, rdVal & m);
  endtask

  // one frame from the distribution end; kind 0 level, 1 word, 2 end
  task automatic frame(input int kind, input logic [31:0] d);
    int k;
    sendLevel <= (kind == 0);
    sendWord  <= (kind == 1);
    sendEnd   <= (kind == 2);
    {nextLevel, curLevel} <= d[15:0];
    wordData  <= d;
    endSync   <= d[0];
    @(posedge clk_sys);
    {sendLevel, sendWord, sendEnd} <= 3'h0;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (txBusy !== 1'h0 && k < 600);
    // room for the last bit's sampling, sync flops and command stage
    repeat (10) @(posedge clk_sys);
    if (k >= 600) begin
      n_fail++;
      results();
    end
  endtask

  // next reply code seen at the distribution end must be the one wanted
  task automatic reply(input logic wantAck);
    int k;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (reqSeen !== 1'h1 && ackSeen !== 1'h1 && k < 300);
    chk("reply code", {31'h0, wantAck}, {31'h0, ackSeen});
    if (k >= 300) begin
      n_fail++;
      results();
    end
  endtask

  // main sequence
  initial begin
    n_fail = 0;
    n_tests = 0;
    {rst, hsel, hwrite, htrans, haddr, hwdata} = {1'h1, 68'h0};
    {sendLevel, sendWord, sendEnd, endSync, hwDataPop} = 5'h0;
    {nextLevel, curLevel, wordData} = 48'h0;
    repeat (10) @(posedge clk_sys);
    rst <= 1'h0;
    rd(OFS_LINK_RESET, '1, 32'(RST_LINK_RESET), "reset reg");
    rd(OFS_LINK_CONTROL, 32'hFFFFFFFF, 32'h0, "control");
    frame(0, 32'h00001234);
    rd(OFS_LINK_STATUS, 32'hFFFFFFFF, 32'h0, "status held");
    xfer(1'h1, OFS_LINK_RESET, 32'h0000000C);
    frame(0, 32'h00001234);
    rd(OFS_LINK_STATUS, 32'hFFFFFFFF, 32'h00030000, "status up");
    rd(OFS_BLOCK_LEVEL, 32'hFFFFFFFF, 32'h0, "level held");
    xfer(1'h1, OFS_LINK_RESET, 32'h00000008);
    frame(0, 32'h00005A3C);
    rd(OFS_BLOCK_LEVEL, 32'hFFFFFFFF, 32'h00005A3C, "level");
    frame(1, 32'hAAAA5555);
    rd(OFS_EB_STATUS, 32'h7FFFFFFF, 32'h00000011, "eb held");
    xfer(1'h1, OFS_LINK_RESET, 32'h0);
    frame(1, 32'h11111111);
    frame(1, 32'h22222222);
    frame(2, 32'h00000001);
    rd(OFS_EB_STATUS, 32'hFFFFFFFF, 32'h80060080, "eb block");
    rd(OFS_LENGTH_PORT, 32'h0000FFFF, 32'h3, "length");
    rd(OFS_DATA_PORT, 32'hFFFFFFFF, 32'h11111111, "word 0");
    rd(OFS_DATA_PORT, 32'hFFFFFFFF, 32'h22222222, "word 1");
    rd(OFS_EB_STATUS, 32'h7FFFFFFF, 32'h00030010, "eb marker");
    rd(OFS_DATA_PORT, 32'hFFFFFFFF, 32'hFFFFFFFF, "marker");
    // stale data on an empty pop is not defined; counts are checked next
    xfer(1'h0, OFS_DATA_PORT, 32'h00000000);
    rd(OFS_EB_STATUS, 32'h7FFFFFFF, 32'h00000011, "eb empty");
    xfer(1'h1, OFS_LINK_CONTROL, 32'h00000010);
    rd(OFS_LINK_CONTROL, 32'hFFFFFFFF, 32'h00000010, "mode");
    chk("mode pin", 32'h1, {31'h0, readoutMode});
    xfer(1'h1, OFS_LINK_CONTROL, 32'h00000001);
    reply(1'h0);
    xfer(1'h1, OFS_LINK_CONTROL, 32'h00000002);
    reply(1'h1);
    xfer(1'h1, OFS_LINK_CONTROL, 32'h00000003);
    reply(1'h0);
    reply(1'h1);
    rd(8'h10, 32'hFFFFFFFF, 32'h0, "unmapped");
    rd(OFS_LINK_STATUS, 32'h0000FFFF, 32'h0, "errors");
    // a pointer moved by the empty pop would miss this word
    frame(1, 32'h33333333);
    rd(OFS_DATA_PORT, '1, 32'h33333333, "after empty pop");
    // hardware readout: bus reads leave the head, the pop input takes it
    xfer(1'h1, OFS_LINK_CONTROL, 32'h00000010);
    frame(1, 32'h44444444);
    rd(OFS_DATA_PORT, '1, 32'h44444444, "hw mode port");
    chk("hw head", 32'h44444444, dataHead[31:0]);
    hwDataPop <= 1'h1;
    @(posedge clk_sys);
    hwDataPop <= 1'h0;
    rd(OFS_EB_STATUS, 32'h7FFFFFFF, 32'h00000011, "hw pop");
    results();
  end
endmodule // tleb_tb
